/* hw/output_function_and_power_on_trigger.sv */
`timescale 1ns/10ps
`default_nettype none
module output_function_and_power_on_trigger
  import seq_cfg_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES
)(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_cmd_wr,
  input wire logic i_cmd_rd,
  input wire logic [7:0] i_cmd_code,
  input wire logic [3:0] i_page,
  input wire logic [31:0] i_wdata,
  input wire logic [15:0] i_good_or_input_pin,
  input wire logic [15:0] i_alarm,
  input wire logic [7:0] i_margin_pwm,
  input wire logic i_special_fault_out,
  input wire logic i_op_on,
  input wire logic [1:0] i_external_control_pin,
  input wire logic [1:0] i_onoff_cfg,
  input wire logic i_sig_send_go,
  input wire logic [3:0] i_sig_send,
  input wire logic i_shared_signature_pin,
  output logic [31:0] o_rdata,
  output logic [7:0] o_margin_or_output_pin_out,
  output logic [7:0] o_margin_or_output_pin_oe_n,
  output logic o_shared_signature_pin_out,
  output logic o_shared_signature_pin_oe_n,
  output logic o_sig_busy,
  output logic [11:0] o_power_on_start,
  output logic [11:0] o_channel_on
);

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [31:0] pin_cfg_ff [N_PINS];
  logic [31:0] nxt_pin_cfg [N_PINS];
  logic [31:0] trig_cfg_ff [N_SEQ];
  logic [31:0] nxt_trig_cfg [N_SEQ];
  logic [31:0] rdata_ff, nxt_rdata;
  logic pin_wr, trig_wr;

  assign pin_wr = i_cmd_wr && i_cmd_code == CMD_PIN_CFG &&
                  i_page < 4'(N_PINS);
  assign trig_wr = i_cmd_wr && i_cmd_code == CMD_TRIG_CFG &&
                   i_page < 4'(N_SEQ);

  always_comb begin
    for (int p = 0; p < N_PINS; p++) begin
      nxt_pin_cfg[p] = pin_cfg_ff[p];
      if (pin_wr && i_page == 4'(p)) begin
        nxt_pin_cfg[p] = i_wdata & ~PIN_RSVD_MASK;
      end
    end
    for (int c = 0; c < N_SEQ; c++) begin
      nxt_trig_cfg[c] = trig_cfg_ff[c];
      if (trig_wr && i_page == 4'(c)) begin
        nxt_trig_cfg[c] = i_wdata & ~TRIG_RSVD_MASK;
      end
    end
    nxt_rdata = rdata_ff;
    if (i_cmd_rd) begin
      nxt_rdata = 32'h0000_0000;
      if (i_cmd_code == CMD_PIN_CFG && i_page < 4'(N_PINS)) begin
        nxt_rdata = pin_cfg_ff[i_page[2:0]];
      end else if (i_cmd_code == CMD_TRIG_CFG &&
                   i_page < 4'(N_SEQ)) begin
        nxt_rdata = trig_cfg_ff[i_page];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int p = 0; p < N_PINS; p++) begin
        pin_cfg_ff[p] <= PIN_CFG_RESET;
      end
      for (int c = 0; c < N_SEQ; c++) begin
        trig_cfg_ff[c] <= TRIG_CFG_RESET;
      end
      rdata_ff <= 32'h0000_0000;
    end else begin
      pin_cfg_ff <= nxt_pin_cfg;
      trig_cfg_ff <= nxt_trig_cfg;
      rdata_ff <= nxt_rdata;
    end
  end

  // ------------------------------------------------------------
  // Millisecond tick for the delay qualifiers
  // ------------------------------------------------------------
  logic [15:0] pre_ff, nxt_pre;
  logic tick_ff, nxt_tick;

  always_comb begin
    nxt_tick = 1'b0;
    nxt_pre = pre_ff + 16'h0001;
    if (pre_ff == 16'(MS_TICK_CYCLES - 1)) begin
      nxt_pre = 16'h0000;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      tick_ff <= nxt_tick;
    end
  end

  // ------------------------------------------------------------
  // Output pin functions
  // ------------------------------------------------------------
  // Reserved and unsupported codes fall to deasserted, which keeps a
  // misprogrammed pin quiet rather than glitching a system signal.
  logic [7:0] raw_level;
  logic [7:0] qual_level;
  logic [7:0] pin_out_ff, nxt_pin_out;
  logic [7:0] pin_oe_n_ff, nxt_pin_oe_n;

  for (genvar g = 0; g < N_PINS; g++) begin : g_pin
    logic [15:0] mask;
    logic [2:0] fn;
    logic active;
    assign mask = pin_cfg_ff[g][MASK_LSB +: N_CH];
    assign fn = pin_cfg_ff[g][2:0];

    always_comb begin
      case (fn)
        FN_MARGIN: raw_level[g] = 1'b0;
        FN_FORCE_ON: raw_level[g] = 1'b1;
        FN_FORCE_OFF: raw_level[g] = 1'b0;
        FN_GOOD_AND: raw_level[g] =
          &(i_good_or_input_pin | ~mask);
        FN_ALARM_OR: raw_level[g] = |(i_alarm & mask);
        FN_SPECIAL: raw_level[g] =
          (g == SPECIAL_FAULT_PIN) ? i_special_fault_out : 1'b0;
        default: raw_level[g] = 1'b0;
      endcase
    end

    qual_delay u_delay (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_ms_tick(tick_ff),
      .i_level(raw_level[g]),
      .i_on_code(pin_cfg_ff[g][ON_LSB +: 4]),
      .i_off_code(pin_cfg_ff[g][OFF_LSB +: 4]),
      .o_level(qual_level[g])
    );

    always_comb begin
      active = raw_level[g];
      if (fn == FN_GOOD_AND || fn == FN_ALARM_OR) begin
        active = qual_level[g];
      end
      nxt_pin_out[g] = pin_cfg_ff[g][POL_BIT] ? active : ~active;
      if (fn == FN_MARGIN) begin
        nxt_pin_out[g] = i_margin_pwm[g];
      end
      nxt_pin_oe_n[g] = 1'b0;
      if (pin_cfg_ff[g][DRIVE_BIT]) begin
        nxt_pin_oe_n[g] = nxt_pin_out[g];
        nxt_pin_out[g] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_out_ff <= 8'h00;
      pin_oe_n_ff <= 8'hff;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_n_ff <= nxt_pin_oe_n;
    end
  end

  // ------------------------------------------------------------
  // Shared signature pin
  // ------------------------------------------------------------
  logic sig_seen;
  logic [3:0] sig_val;

  sig_pin_link u_sig (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_send_go(i_sig_send_go),
    .i_send_sig(i_sig_send),
    .i_pin(i_shared_signature_pin),
    .o_pin_out(o_shared_signature_pin_out),
    .o_pin_oe_n(o_shared_signature_pin_oe_n),
    .o_busy(o_sig_busy),
    .o_seen(sig_seen),
    .o_seen_sig(sig_val)
  );

  // ------------------------------------------------------------
  // Power-on triggers
  // ------------------------------------------------------------
  logic trig_a, trig_b;
  logic [11:0] started_ff, nxt_started;
  logic [11:0] start_ff, nxt_start;
  logic [11:0] cond;

  // Each on/off config bit makes one source necessary.
  assign trig_a = (!i_onoff_cfg[0] || i_op_on) &&
                  (!i_onoff_cfg[1] || i_external_control_pin[0]);
  assign trig_b = (!i_onoff_cfg[0] || i_op_on) &&
                  (!i_onoff_cfg[1] || i_external_control_pin[1]);

  for (genvar c = 0; c < N_SEQ; c++) begin : g_seq
    logic [15:0] mask;
    logic [3:0] choice;
    assign mask = trig_cfg_ff[c][MASK_LSB +: N_CH];
    assign choice = trig_cfg_ff[c][SIG_LSB +: 4];

    always_comb begin
      case (trig_cfg_ff[c][TRIG_LSB +: 2])
        TR_GLOBAL: cond[c] =
          trig_cfg_ff[c][PICK_BIT] ? trig_b : trig_a;
        TR_GOOD_AND: cond[c] =
          &(i_good_or_input_pin | ~mask);
        TR_SIGNATURE: cond[c] = sig_seen && choice != 4'h0 &&
          sig_val == choice;
        default: cond[c] = 1'b0;
      endcase
    end
  end

  // A config write re-arms the channel even while it is on: o_channel_on
  // drops, and the channel starts again once its trigger condition holds.
  always_comb begin
    nxt_started = started_ff;
    nxt_start = 12'h000;
    for (int c = 0; c < N_SEQ; c++) begin
      if (trig_wr && i_page == 4'(c)) begin
        nxt_started[c] = 1'b0;
      end else if (cond[c] && !started_ff[c]) begin
        nxt_started[c] = 1'b1;
        nxt_start[c] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      started_ff <= 12'h000;
      start_ff <= 12'h000;
    end else begin
      started_ff <= nxt_started;
      start_ff <= nxt_start;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_margin_or_output_pin_out = pin_out_ff;
  assign o_margin_or_output_pin_oe_n = pin_oe_n_ff;
  assign o_power_on_start = start_ff;
  assign o_channel_on = started_ff;

endmodule
`default_nettype wire

/* include/seq_cfg_pkg.sv */
`default_nettype none
package seq_cfg_pkg;

  // ------------------------------------------------------------
  // Command codes and geometry
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_PIN_CFG = 8'he7;
  localparam logic [7:0] CMD_TRIG_CFG = 8'he8;
  localparam int N_PINS = 8;
  localparam int N_SEQ = 12;
  localparam int N_CH = 16;
  localparam int SPECIAL_FAULT_PIN = 7;

  // ------------------------------------------------------------
  // Field positions, masks and reset values
  // ------------------------------------------------------------
  localparam int MASK_LSB = 16;
  localparam int OFF_LSB = 12;
  localparam int ON_LSB = 8;
  localparam int SIG_LSB = 8;
  localparam int DRIVE_BIT = 7;
  localparam int POL_BIT = 6;
  localparam int PICK_BIT = 0;
  localparam int TRIG_LSB = 4;
  localparam logic [31:0] PIN_RSVD_MASK = 32'h0000_0038;
  localparam logic [31:0] TRIG_RSVD_MASK = 32'h0000_f0ce;
  localparam logic [31:0] PIN_CFG_RESET = 32'h0000_0002;
  localparam logic [31:0] TRIG_CFG_RESET = 32'h0000_0000;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int SIG_PULSE_NS = 1000;
  localparam int SIG_PULSE_CYCLES =
    (SIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SIG_GAP_NS = 5000;
  localparam int SIG_GAP_CYCLES =
    (SIG_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_MARGIN = 3'b000,
    FN_FORCE_ON = 3'b001,
    FN_FORCE_OFF = 3'b010,
    FN_GOOD_AND = 3'b011,
    FN_ALARM_OR = 3'b100,
    FN_SPECIAL = 3'b101
  } pin_func_type;

  typedef enum logic [1:0] {
    TR_GLOBAL = 2'b00,
    TR_GOOD_AND = 2'b01,
    TR_SIGNATURE = 2'b10
  } trig_type;

  typedef enum logic [1:0] {
    SG_IDLE = 2'b00,
    SG_LOW = 2'b01,
    SG_HIGH = 2'b10
  } sig_state_type;

  function automatic logic [11:0] delay_ms(input logic [3:0] code);
    logic [11:0] ms;
    ms = 12'h000;
    case (code)
      4'h0: ms = 12'd0;
      4'h1: ms = 12'd5;
      4'h2: ms = 12'd10;
      4'h3: ms = 12'd20;
      4'h4: ms = 12'd40;
      4'h5: ms = 12'd60;
      4'h6: ms = 12'd80;
      4'h7: ms = 12'd100;
      4'h8: ms = 12'd200;
      4'h9: ms = 12'd400;
      4'ha: ms = 12'd600;
      4'hb: ms = 12'd800;
      4'hc: ms = 12'd1000;
      4'hd: ms = 12'd1500;
      4'he: ms = 12'd2000;
      default: ms = 12'd4000;
    endcase
    return ms;
  endfunction

endpackage
`default_nettype wire

/* hw/qual_delay.sv */
`timescale 1ns/10ps
`default_nettype none
module qual_delay
  import seq_cfg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ms_tick,
  input wire logic i_level,
  input wire logic [3:0] i_on_code,
  input wire logic [3:0] i_off_code,
  output logic o_level
);

  // ------------------------------------------------------------
  // Qualification counter
  // ------------------------------------------------------------
  // The count runs on the shared millisecond tick, so the first
  // millisecond may be short by up to one tick; this saves a wide
  // cycle counter per pin.
  logic out_ff, nxt_out;
  logic last_ff, nxt_last;
  logic [11:0] cnt_ff, nxt_cnt;
  logic [11:0] target;

  always_comb begin
    nxt_last = i_level;
    nxt_out = out_ff;
    nxt_cnt = cnt_ff;
    target = i_level ? delay_ms(i_on_code) : delay_ms(i_off_code);
    if (i_level != last_ff) begin
      nxt_cnt = 12'h000;
    end else if (i_level != out_ff) begin
      if (cnt_ff >= target) begin
        nxt_out = i_level;
        nxt_cnt = 12'h000;
      end else if (i_ms_tick) begin
        nxt_cnt = cnt_ff + 12'h001;
      end
    end else begin
      nxt_cnt = 12'h000;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_ff <= 1'b0;
      last_ff <= 1'b0;
      cnt_ff <= 12'h000;
    end else begin
      out_ff <= nxt_out;
      last_ff <= nxt_last;
      cnt_ff <= nxt_cnt;
    end
  end

  assign o_level = out_ff;

endmodule
`default_nettype wire

/* hw/sig_pin_link.sv */
`timescale 1ns/10ps
`default_nettype none
module sig_pin_link
  import seq_cfg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_send_go,
  input wire logic [3:0] i_send_sig,
  input wire logic i_pin,
  output logic o_pin_out,
  output logic o_pin_oe_n,
  output logic o_busy,
  output logic o_seen,
  output logic [3:0] o_seen_sig
);

  // ------------------------------------------------------------
  // Sender: a signature is sent as that many low pulses
  // ------------------------------------------------------------
  sig_state_type st_ff, nxt_st;
  logic [3:0] left_ff, nxt_left;
  logic [7:0] tmr_ff, nxt_tmr;
  logic oe_n_ff, nxt_oe_n;
  logic busy_ff, nxt_busy;

  // The quiet gap after a burst outlasts the receiver's end-of-burst
  // wait, so two bursts sent back to back are never merged into one.
  always_comb begin
    nxt_st = st_ff;
    nxt_left = left_ff;
    nxt_tmr = tmr_ff;
    nxt_oe_n = 1'b1;
    case (st_ff)
      SG_IDLE: begin
        if (tmr_ff != 8'h00) begin
          nxt_tmr = tmr_ff - 8'h01;
        end else if (i_send_go && i_send_sig != 4'h0) begin
          nxt_st = SG_LOW;
          nxt_left = i_send_sig;
          nxt_tmr = 8'(SIG_PULSE_CYCLES - 1);
          nxt_oe_n = 1'b0;
        end
      end
      SG_LOW: begin
        nxt_oe_n = 1'b0;
        if (tmr_ff == 8'h00) begin
          nxt_st = SG_HIGH;
          nxt_oe_n = 1'b1;
          nxt_left = left_ff - 4'h1;
          nxt_tmr = 8'(SIG_PULSE_CYCLES - 1);
        end else begin
          nxt_tmr = tmr_ff - 8'h01;
        end
      end
      SG_HIGH: begin
        if (tmr_ff != 8'h00) begin
          nxt_tmr = tmr_ff - 8'h01;
        end else if (left_ff == 4'h0) begin
          nxt_tmr = 8'(SIG_GAP_CYCLES);
          nxt_st = SG_IDLE;
        end else begin
          nxt_st = SG_LOW;
          nxt_oe_n = 1'b0;
          nxt_tmr = 8'(SIG_PULSE_CYCLES - 1);
        end
      end
      default: nxt_st = SG_IDLE;
    endcase
    nxt_busy = (nxt_st != SG_IDLE) || (nxt_tmr != 8'h00);
  end

  // ------------------------------------------------------------
  // Receiver: counts falling edges until the pin rests high
  // ------------------------------------------------------------
  logic prev_ff, nxt_prev;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] idle_ff, nxt_idle;
  logic seen_ff, nxt_seen;
  logic [3:0] sig_ff, nxt_sig;

  always_comb begin
    nxt_prev = i_pin;
    nxt_cnt = cnt_ff;
    nxt_idle = idle_ff;
    nxt_seen = 1'b0;
    nxt_sig = sig_ff;
    if (prev_ff && !i_pin) begin
      nxt_idle = 8'h00;
      if (cnt_ff != 4'hf) begin
        nxt_cnt = cnt_ff + 4'h1;
      end
    end else if (!i_pin) begin
      nxt_idle = 8'h00;
    end else if (idle_ff != 8'(SIG_GAP_CYCLES)) begin
      nxt_idle = idle_ff + 8'h01;
    end else if (cnt_ff != 4'h0) begin
      nxt_seen = 1'b1;
      nxt_sig = cnt_ff;
      nxt_cnt = 4'h0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= SG_IDLE;
      left_ff <= 4'h0;
      tmr_ff <= 8'h00;
      oe_n_ff <= 1'b1;
      busy_ff <= 1'b0;
      prev_ff <= 1'b1;
      cnt_ff <= 4'h0;
      idle_ff <= 8'h00;
      seen_ff <= 1'b0;
      sig_ff <= 4'h0;
    end else begin
      st_ff <= nxt_st;
      left_ff <= nxt_left;
      tmr_ff <= nxt_tmr;
      oe_n_ff <= nxt_oe_n;
      busy_ff <= nxt_busy;
      prev_ff <= nxt_prev;
      cnt_ff <= nxt_cnt;
      idle_ff <= nxt_idle;
      seen_ff <= nxt_seen;
      sig_ff <= nxt_sig;
    end
  end

  // The pin is open drain: it only ever pulls low.
  assign o_pin_out = 1'b0;
  assign o_pin_oe_n = oe_n_ff;
  assign o_busy = busy_ff;
  assign o_seen = seen_ff;
  assign o_seen_sig = sig_ff;

endmodule
`default_nettype wire

/* tb/ofpt_props.sv */
`timescale 1ns/10ps
`default_nettype none
module ofpt_props
  import seq_cfg_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES
)(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_cmd_wr,
  input wire logic i_cmd_rd,
  input wire logic [7:0] i_cmd_code,
  input wire logic [3:0] i_page,
  input wire logic [31:0] i_wdata,
  input wire logic i_sig_send_go,
  input wire logic [3:0] i_sig_send,
  input wire logic [31:0] o_rdata,
  input wire logic [7:0] o_margin_or_output_pin_out,
  input wire logic [7:0] o_margin_or_output_pin_oe_n,
  input wire logic o_shared_signature_pin_out,
  input wire logic o_shared_signature_pin_oe_n,
  input wire logic o_sig_busy,
  input wire logic [11:0] o_power_on_start,
  input wire logic [11:0] o_channel_on
);
  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  logic [7:0] pout;
  logic [7:0] poe;
  logic soe;
  assign pout = o_margin_or_output_pin_out;
  assign poe = o_margin_or_output_pin_oe_n;
  assign soe = o_shared_signature_pin_oe_n;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);
  sequence s_pin_wr(logic [3:0] p, logic [7:0] v);
    i_cmd_wr && i_cmd_code == CMD_PIN_CFG && i_page == p &&
      i_wdata[7:0] == v;
  endsequence
  sequence s_low8;
    (!soe) [*8];
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_PUSH_HIGH: assert property (s_pin_wr(4'h0, 8'h41) |=> ##1
    (pout[0] && !poe[0])) else $error("forced high pin not driven");
  AST_ACTIVE_LOW: assert property (s_pin_wr(4'h0, 8'h01) |=> ##1
    (!pout[0] && !poe[0])) else $error("active low pin not low");
  AST_OD_RELEASE: assert property (s_pin_wr(4'h0, 8'hc1) |=> ##1
    (!pout[0] && poe[0])) else $error("open drain pin not released");
  AST_NO_SPECIAL: assert property (s_pin_wr(4'h3, 8'h45) |=> ##1
    !pout[3]) else $error("special function on wrong pin");
  AST_PIN_RSVD: assert property (i_cmd_rd && i_cmd_code == CMD_PIN_CFG
    |=> o_rdata[5:3] == 3'h0) else $error("reserved pin bits not zero");
  AST_SIG_GO: assert property (i_sig_send_go && !o_sig_busy &&
    i_sig_send != 4'h0 |=> !soe) else $error("send did not pull pin");
  AST_SIG_PULSE: assert property ($fell(soe) |-> s_low8 ##1
    s_low8 ##1 (!soe) [*4] ##1 soe) else $error("low pulse not 20 cycles");
  AST_SIG_OPEN: assert property (o_shared_signature_pin_out == 1'b0)
    else $error("shared pin driven high");
  AST_START_ONE: assert property (o_power_on_start != 12'h000 |=>
    (o_power_on_start & $past(o_power_on_start)) == 12'h000)
    else $error("start pulse longer than one cycle");
  AST_START_ON: assert property (
    (o_power_on_start & ~o_channel_on) == 12'h000)
    else $error("start without channel on");
  AST_ON_START: assert property ((o_channel_on &
    ~$past(o_channel_on) & ~o_power_on_start) == 12'h000)
    else $error("channel on without start");
endmodule
bind output_function_and_power_on_trigger ofpt_props #(
  .MS_TICK_CYCLES(MS_TICK_CYCLES)
) u_props (
  .i_mclk(i_mclk),
  .i_rstn(i_rstn),
  .i_cmd_wr(i_cmd_wr),
  .i_cmd_rd(i_cmd_rd),
  .i_cmd_code(i_cmd_code),
  .i_page(i_page),
  .i_wdata(i_wdata),
  .i_sig_send_go(i_sig_send_go),
  .i_sig_send(i_sig_send),
  .o_rdata(o_rdata),
  .o_margin_or_output_pin_out(o_margin_or_output_pin_out),
  .o_margin_or_output_pin_oe_n(o_margin_or_output_pin_oe_n),
  .o_shared_signature_pin_out(o_shared_signature_pin_out),
  .o_shared_signature_pin_oe_n(o_shared_signature_pin_oe_n),
  .o_sig_busy(o_sig_busy),
  .o_power_on_start(o_power_on_start),
  .o_channel_on(o_channel_on)
);
`default_nettype wire

/* tb/peer_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module peer_sequencer (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_pin,
  output logic o_pull_n,
  output logic [4:0] o_falls
);
  // ------------------------------------------------------------
  // Open-drain sender and edge observer
  // ------------------------------------------------------------
  logic last_ff;
  initial o_pull_n = 1'b1;
  // The peer only ever pulls low, so the pull-up owns the high level.
  task automatic send(input int n, input int w);
    for (int i = 0; i < n; i++) begin
      @(posedge i_mclk);
      o_pull_n <= 1'b0;
      repeat (w) @(posedge i_mclk);
      o_pull_n <= 1'b1;
      repeat (w - 1) @(posedge i_mclk);
    end
  endtask
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      last_ff <= 1'b1;
      o_falls <= 5'h00;
    end else begin
      last_ff <= i_pin;
      if (last_ff && !i_pin) begin
        o_falls <= o_falls + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/output_function_and_power_on_trigger_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module output_function_and_power_on_trigger_bench
  import seq_cfg_pkg::*;
;
  // ------------------------------------------------------------
  // Stimulus and wiring
  // ------------------------------------------------------------
  localparam logic [47:0] FV = 48'h02_c2_81_c1_01_41;
  localparam logic [11:0] FE = 12'h812;
  localparam logic [223:0] TV = {32'h220, 32'h30, 32'h20, 32'h320,
    32'h20_0010, 32'h1, 32'h0};
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic sfo = 1'b0;
  logic [7:0] code = 8'h00;
  logic [3:0] page = 4'h0;
  logic [3:0] ssig = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [15:0] good = 16'h0;
  logic [15:0] alarm = 16'h0;
  logic [7:0] pwm = 8'h00;
  logic [1:0] ctrl = 2'h0;
  logic op = 1'b0;
  logic [1:0] onoff = 2'h2;
  logic [31:0] rdata;
  logic [7:0] pout;
  logic [7:0] poe;
  logic soe;
  logic busy;
  logic [11:0] start;
  logic [11:0] chon;
  logic pull_n;
  logic [4:0] falls;
  logic shared;
  int fails = 0;
  int checks = 0;
  int n_starts = 0;
  // Wired-AND with a pull-up: either party pulling low wins.
  assign shared = soe & pull_n;
  always #25 i_mclk = ~i_mclk;
  always @(posedge i_mclk) n_starts += $countones(start);
  output_function_and_power_on_trigger #(.MS_TICK_CYCLES(10)) u_dut (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_cmd_wr(wr),
    .i_cmd_rd(rd),
    .i_cmd_code(code),
    .i_page(page),
    .i_wdata(wdata),
    .i_good_or_input_pin(good),
    .i_alarm(alarm),
    .i_margin_pwm(pwm),
    .i_special_fault_out(sfo),
    .i_op_on(op),
    .i_external_control_pin(ctrl),
    .i_onoff_cfg(onoff),
    .i_sig_send_go(go),
    .i_sig_send(ssig),
    .i_shared_signature_pin(shared),
    .o_rdata(rdata),
    .o_margin_or_output_pin_out(pout),
    .o_margin_or_output_pin_oe_n(poe),
    .o_shared_signature_pin_out(),
    .o_shared_signature_pin_oe_n(soe),
    .o_sig_busy(busy),
    .o_power_on_start(start),
    .o_channel_on(chon)
  );
  peer_sequencer u_peer (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_pin(shared),
    .o_pull_n(pull_n),
    .o_falls(falls)
  );
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic conclude();
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic put(input logic [7:0] c, input logic [3:0] p,
    input logic [31:0] d);
    @(negedge i_mclk);
    wr = 1'b1;
    code = c;
    page = p;
    wdata = d;
    @(negedge i_mclk);
    wr = 1'b0;
  endtask
  task automatic get(input logic [7:0] c, input logic [3:0] p,
    input logic [31:0] exp);
    @(negedge i_mclk);
    rd = 1'b1;
    code = c;
    page = p;
    @(negedge i_mclk);
    rd = 1'b0;
    cmp(rdata, exp);
  endtask
  // A missed level ends the run, since later steps depend on it.
  task automatic wait_lvl(input bit on, input int k, input logic v,
    input int n);
    for (int i = 0; i < n && (on ? chon[k] : pout[k]) !== v; i++) idle(1);
    cmp({31'h0, on ? chon[k] : pout[k]}, {31'h0, v});
    if ((on ? chon[k] : pout[k]) !== v) begin
      conclude();
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    idle(2);
    cmp({24'h0, pout, poe}, 32'hff00);
    for (int p = 0; p < N_PINS; p++) get(CMD_PIN_CFG, 4'(p), PIN_CFG_RESET);
    for (int p = 0; p < N_SEQ; p++) get(CMD_TRIG_CFG, 4'(p), TRIG_CFG_RESET);
  endtask
  task automatic t_pin_force();
    for (int i = 0; i < 6; i++) begin
      put(CMD_PIN_CFG, 4'h0, {24'h0, FV[8*i +: 8]});
      idle(2);
      cmp({30'h0, pout[0], poe[0]}, {30'h0, FE[2*i +: 2]});
    end
  endtask
  task automatic t_pin_misc();
    put(CMD_PIN_CFG, 4'h2, 32'hffff_fffa);
    get(CMD_PIN_CFG, 4'h2, 32'hffff_ffc2);
    put(CMD_PIN_CFG, 4'h1, 32'h0);
    pwm = 8'h02;
    idle(2);
    cmp({31'h0, pout[1]}, 32'h1);
    pwm = 8'h00;
    idle(2);
    cmp({31'h0, pout[1]}, 32'h0);
    sfo = 1'b1;
    put(CMD_PIN_CFG, 4'h7, 32'h45);
    put(CMD_PIN_CFG, 4'h3, 32'h45);
    idle(2);
    cmp({30'h0, pout[7], pout[3]}, 32'h2);
  endtask
  task automatic t_good();
    put(CMD_PIN_CFG, 4'h4, 32'h0006_0043);
    good = 16'h0003;
    idle(6);
    cmp({31'h0, pout[4]}, 32'h0);
    good = 16'h0007;
    wait_lvl(1'b0, 4, 1'b1, 6);
    put(CMD_PIN_CFG, 4'h4, 32'h0006_2143);
    good = 16'h0000;
    idle(80);
    cmp({31'h0, pout[4]}, 32'h1);
    wait_lvl(1'b0, 4, 1'b0, 40);
    good = 16'h0006;
    idle(30);
    good = 16'h0004;
    idle(1);
    good = 16'h0006;
    idle(38);
    cmp({31'h0, pout[4]}, 32'h0);
    wait_lvl(1'b0, 4, 1'b1, 30);
  endtask
  task automatic t_alarm();
    put(CMD_PIN_CFG, 4'h5, 32'h0003_0044);
    alarm = 16'h0020;
    idle(6);
    cmp({31'h0, pout[5]}, 32'h0);
    alarm = 16'h0022;
    wait_lvl(1'b0, 5, 1'b1, 6);
    alarm = 16'h0000;
    wait_lvl(1'b0, 5, 1'b0, 6);
  endtask
  task automatic t_trig();
    put(CMD_TRIG_CFG, 4'hb, 32'hffff_ffff);
    get(CMD_TRIG_CFG, 4'hb, 32'hffff_0f31);
    put(CMD_TRIG_CFG, 4'hb, 32'h0);
    for (int i = 0; i < 7; i++) put(CMD_TRIG_CFG, 4'(i), TV[32*i +: 32]);
    ctrl = 2'h2;
    wait_lvl(1'b1, 1, 1'b1, 6);
    cmp({31'h0, chon[0]}, 32'h0);
    ctrl = 2'h0;
    good = 16'h0020;
    wait_lvl(1'b1, 2, 1'b1, 6);
    u_peer.send(3, 20);
    wait_lvl(1'b1, 3, 1'b1, 300);
    cmp({25'h0, chon[6], chon[4], falls}, 32'h3);
    @(negedge i_mclk);
    go = 1'b1;
    ssig = 4'h2;
    @(negedge i_mclk);
    go = 1'b0;
    cmp({30'h0, soe, busy}, 32'h1);
    wait_lvl(1'b1, 6, 1'b1, 400);
    cmp({27'h0, falls}, 32'h5);
    ctrl = 2'h1;
    wait_lvl(1'b1, 0, 1'b1, 6);
    idle(3);
    cmp({20'h0, chon}, 32'h0fcf);
    ctrl = 2'h0;
    put(CMD_TRIG_CFG, 4'h1, 32'h1);
    idle(2);
    cmp({31'h0, chon[1]}, 32'h0);
    ctrl = 2'h2;
    wait_lvl(1'b1, 1, 1'b1, 6);
    onoff = 2'h3;
    put(CMD_TRIG_CFG, 4'h1, 32'h1);
    idle(4);
    cmp({31'h0, chon[1]}, 32'h0);
    op = 1'b1;
    wait_lvl(1'b1, 1, 1'b1, 6);
    idle(2);
    cmp(n_starts, 32'd12);
  endtask
  initial begin
    repeat (16) @(negedge i_mclk);
    i_rstn = 1'b1;
    t_reset();
    t_pin_force();
    t_pin_misc();
    t_good();
    t_alarm();
    t_trig();
    conclude();
  end
endmodule
`default_nettype wire
